// file: rtl/dtc_pkg.sv
package dtc_pkg;

    // ----------------------------------------------------------------
    // register map, one aligned 32-bit word each, data in bits 7:0
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_CTRL = 12'h004;
    localparam logic [11:0] OFS_LOW0 = 12'h008;
    localparam logic [11:0] OFS_HIGH0 = 12'h00C;
    localparam logic [11:0] OFS_LOW1 = 12'h010;
    localparam logic [11:0] OFS_HIGH1 = 12'h014;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;

    // ----------------------------------------------------------------
    // control register bit positions
    // ----------------------------------------------------------------
    localparam int unsigned CTL_OVF1 = 7;
    localparam int unsigned CTL_RUN1 = 6;
    localparam int unsigned CTL_OVF0 = 5;
    localparam int unsigned CTL_RUN0 = 4;
    localparam int unsigned CTL_XE1 = 3;
    localparam int unsigned CTL_XT1 = 2;
    localparam int unsigned CTL_XE0 = 1;
    localparam int unsigned CTL_XT0 = 0;

    // ----------------------------------------------------------------
    // operating modes from {mode_bit_hi, mode_bit_lo}
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_PRESCALED13 = 2'h0;
    localparam logic [1:0] MODE_FULL16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // ----------------------------------------------------------------
    // machine cycle: clocks per cycle, counter width, last count
    // ----------------------------------------------------------------
    localparam int unsigned MC_CLKS = 12;
    localparam int unsigned MC_W = 4;
    localparam logic [MC_W-1:0] MC_LAST = 4'(MC_CLKS - 1);

    // ----------------------------------------------------------------
    // pin sampler lanes
    // ----------------------------------------------------------------
    localparam int unsigned PIN_N = 4;
    localparam int unsigned PIN_EV0 = 0;
    localparam int unsigned PIN_EV1 = 1;
    localparam int unsigned PIN_GT0 = 2;
    localparam int unsigned PIN_GT1 = 3;

    // one nibble of the mode register, bit 3 of each is the gate enable
    typedef struct packed {
        logic gate_enable;
        logic counter_select;
        logic mode_bit_hi;
        logic mode_bit_lo;
    } dtc_tmr_cfg_t;

    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } dtc_cnt_t;

    typedef struct packed {
        logic ovf;
        dtc_cnt_t cnt;
    } dtc_step_t;

endpackage : dtc_pkg

// file: rtl/dtc_pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module dtc_pin_sampler (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [dtc_pkg::PIN_N-1:0] pin_i,
    output logic [dtc_pkg::PIN_N-1:0] level_o,
    output logic [dtc_pkg::PIN_N-1:0] fall_o
);

    // ----------------------------------------------------------------
    // per-pin level register and falling-edge pulse
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < dtc_pkg::PIN_N; g++) begin : g_pin
            logic level_reg;
            logic level_next;
            logic fall_reg;
            logic fall_next;

            // idle-high pins, so reset to 1 avoids a false edge
            always_comb begin
                level_next = pin_i[g];
                fall_next = level_reg & ~pin_i[g];
            end

            always_ff @(posedge clock_i) begin
                if (!reset_n_i) begin
                    level_reg <= 1'b1;
                    fall_reg <= 1'b0;
                end else begin
                    level_reg <= level_next;
                    fall_reg <= fall_next;
                end
            end

            assign level_o[g] = level_reg;
            assign fall_o[g] = fall_reg;
        end
    endgenerate

endmodule : dtc_pin_sampler

`default_nettype wire

// file: rtl/dtc_timer_pair.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

//
// Overview of operation
// RULE_01: each timer counts machine cycles when counter_select is 0, pin events when it is 1.
// RULE_02: four modes per timer are picked by mode_bit_hi and mode_bit_lo.
// RULE_03: mode 0 counts 13 bits, the high byte over the low five bits of the low byte.
// RULE_04: a roll-over of the active counter from all ones to zero sets the overflow flag.
// RULE_05: a timer counts only with its run bit set and its gate off or its gate pin high; timer 1 ignores run1 while timer 0 is in mode 3.
// RULE_06: setting a run bit resumes from the held count without clearing it.
// RULE_07: mode register bit 7 gates timer 1 and bit 3 gates timer 0.
// RULE_08: mode 1 is mode 0 using all sixteen bits.
// RULE_09: mode 2 counts the low byte and reloads it from the high byte on overflow.
// RULE_10: timer 1 in mode 3 holds its count as if its run bit were clear.
// RULE_11: timer 0 mode 3 low byte is an 8-bit counter with timer 0's controls and flag.
// RULE_12: timer 0 mode 3 high byte counts machine cycles, runs on timer 1's run bit, sets its flag.
// RULE_13: with timer 0 in mode 3, timer 1 still runs outside mode 3 and drives the baud tick.
// RULE_14: control register holds ovf1, run1, ovf0, run0, irq1 edge/type, irq0 edge/type.
// RULE_15: an overflow flag clears when its interrupt is vectored, and software may write it.
// RULE_16: type bit set means falling edge, clear means low level; edge flag clears on service.
//

module dtc_timer_pair (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [dtc_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic event0_i,
    input wire logic event1_i,
    input wire logic ext_gate_pin0_i,
    input wire logic ext_gate_pin1_i,
    input wire logic svc_timer0_i,
    input wire logic svc_timer1_i,
    input wire logic svc_ext0_i,
    input wire logic svc_ext1_i,
    output logic timer0_irq_o,
    output logic timer1_irq_o,
    output logic ext_irq0_o,
    output logic ext_irq1_o,
    output logic baud_tick_o
);

    // ----------------------------------------------------------------
    // counter step for modes 0, 1 and 2; mode 3 is handled by caller
    // ----------------------------------------------------------------
    function automatic dtc_pkg::dtc_step_t step_cnt(
        input logic [1:0] mode,
        input dtc_pkg::dtc_cnt_t c,
        input logic inc
    );
        dtc_pkg::dtc_step_t r;
        logic [13:0] w13;
        logic [16:0] w16;
        logic [8:0] w8;
        r.ovf = 1'b0;
        r.cnt = c;
        w13 = {1'b0, c.high_byte, c.low_byte[4:0]} + 14'h0001;
        w16 = {1'b0, c.high_byte, c.low_byte} + 17'h00001;
        w8 = {1'b0, c.low_byte} + 9'h001;
        if (inc) begin
            case (mode)
                dtc_pkg::MODE_PRESCALED13: begin
                    // top three low-byte bits are left alone
                    r.cnt.high_byte = w13[12:5]; // RULE_03
                    r.cnt.low_byte[4:0] = w13[4:0]; // RULE_03
                    r.ovf = w13[13]; // RULE_04
                end
                dtc_pkg::MODE_FULL16: begin
                    r.cnt.high_byte = w16[15:8]; // RULE_08
                    r.cnt.low_byte = w16[7:0]; // RULE_08
                    r.ovf = w16[16]; // RULE_04
                end
                dtc_pkg::MODE_RELOAD8: begin
                    if (w8[8]) begin
                        r.cnt.low_byte = c.high_byte; // RULE_09
                    end else begin
                        r.cnt.low_byte = w8[7:0]; // RULE_09
                    end
                    r.ovf = w8[8]; // RULE_09
                end
                default: begin
                    r.ovf = 1'b0; // RULE_10
                end
            endcase
        end
        return r;
    endfunction : step_cnt

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [dtc_pkg::MC_W-1:0] mc_cnt_reg;
    logic [dtc_pkg::MC_W-1:0] mc_cnt_next;
    logic mc_tick_reg;
    logic mc_tick_next;
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    dtc_pkg::dtc_cnt_t cnt0_reg;
    dtc_pkg::dtc_cnt_t cnt0_next;
    dtc_pkg::dtc_cnt_t cnt1_reg;
    dtc_pkg::dtc_cnt_t cnt1_next;
    logic baud_reg;
    logic baud_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ready_reg;
    logic ready_next;
    logic err_reg;
    logic err_next;
    logic [dtc_pkg::PIN_N-1:0] pin_level;
    logic [dtc_pkg::PIN_N-1:0] pin_fall;

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    dtc_pin_sampler u_pins (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .pin_i({ext_gate_pin1_i, ext_gate_pin0_i, event1_i, event0_i}),
        .level_o(pin_level),
        .fall_o(pin_fall)
    );

    // ----------------------------------------------------------------
    // machine cycle prescaler
    // ----------------------------------------------------------------
    always_comb begin
        mc_tick_next = (mc_cnt_reg == dtc_pkg::MC_LAST);
        mc_cnt_next = mc_tick_next ? '0 : mc_cnt_reg + 4'h1;
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            mc_cnt_reg <= '0;
            mc_tick_reg <= 1'b0;
        end else begin
            mc_cnt_reg <= mc_cnt_next;
            mc_tick_reg <= mc_tick_next;
        end
    end

    // ----------------------------------------------------------------
    // apb slave: answer latched in setup, pready high in access phase
    // ----------------------------------------------------------------
    logic setup_phase;
    logic wr_en;
    logic [7:0] wbyte;

    assign setup_phase = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & ready_reg & pwrite_i & pstrb_i[0]
                   & ~err_reg;
    assign wbyte = pwdata_i[7:0];

    // read data is taken from the state seen in the setup cycle
    always_comb begin
        rdata_next = 32'h00000000;
        err_next = 1'b0;
        ready_next = setup_phase;
        if (setup_phase) begin
            if (paddr_i == dtc_pkg::OFS_MODE) begin
                rdata_next[7:0] = mode_reg;
            end else if (paddr_i == dtc_pkg::OFS_CTRL) begin
                rdata_next[7:0] = ctrl_reg;
            end else if (paddr_i == dtc_pkg::OFS_LOW0) begin
                rdata_next[7:0] = cnt0_reg.low_byte;
            end else if (paddr_i == dtc_pkg::OFS_HIGH0) begin
                rdata_next[7:0] = cnt0_reg.high_byte;
            end else if (paddr_i == dtc_pkg::OFS_LOW1) begin
                rdata_next[7:0] = cnt1_reg.low_byte;
            end else if (paddr_i == dtc_pkg::OFS_HIGH1) begin
                rdata_next[7:0] = cnt1_reg.high_byte;
            end else begin
                err_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h00000000;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg <= err_next;
        end
    end

    // ----------------------------------------------------------------
    // timer and control datapath
    // ----------------------------------------------------------------
    dtc_pkg::dtc_tmr_cfg_t cfg0;
    dtc_pkg::dtc_tmr_cfg_t cfg1;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split0;
    logic inc0;
    logic inc1;
    logic inc_hi;
    logic ovf0;
    logic ovf1_set;
    dtc_pkg::dtc_step_t st0;
    dtc_pkg::dtc_step_t st1;
    logic [8:0] lo_w;
    logic [8:0] hi_w;

    // gate bits sit at 7 and 3 through the nibble split
    assign cfg1 = dtc_pkg::dtc_tmr_cfg_t'(mode_reg[7:4]); // RULE_07
    assign cfg0 = dtc_pkg::dtc_tmr_cfg_t'(mode_reg[3:0]); // RULE_07
    assign mode0 = {cfg0.mode_bit_hi, cfg0.mode_bit_lo}; // RULE_02
    assign mode1 = {cfg1.mode_bit_hi, cfg1.mode_bit_lo}; // RULE_02
    assign split0 = (mode0 == dtc_pkg::MODE_SPLIT);

    // count source and enable; run never touches the count itself
    assign inc0 = (cfg0.counter_select ? pin_fall[dtc_pkg::PIN_EV0]
                   : mc_tick_reg) // RULE_01
                  & ctrl_reg[dtc_pkg::CTL_RUN0] // RULE_05 RULE_06
                  & (~cfg0.gate_enable | pin_level[dtc_pkg::PIN_GT0]);
    assign inc1 = (cfg1.counter_select ? pin_fall[dtc_pkg::PIN_EV1]
                   : mc_tick_reg) // RULE_01
                  & (ctrl_reg[dtc_pkg::CTL_RUN1] | split0) // RULE_05 RULE_06
                  & (~cfg1.gate_enable | pin_level[dtc_pkg::PIN_GT1])
                  & (mode1 != dtc_pkg::MODE_SPLIT); // RULE_10 RULE_13
    // split high byte ignores counter_select and gate
    assign inc_hi = mc_tick_reg & ctrl_reg[dtc_pkg::CTL_RUN1]; // RULE_12

    assign lo_w = {1'b0, cnt0_reg.low_byte} + 9'h001;
    assign hi_w = {1'b0, cnt0_reg.high_byte} + 9'h001;
    assign st0 = step_cnt(mode0, cnt0_reg, inc0);
    assign st1 = step_cnt(mode1, cnt1_reg, inc1);

    always_comb begin
        cnt0_next = cnt0_reg;
        cnt1_next = cnt1_reg;
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        ovf0 = 1'b0;
        ovf1_set = 1'b0;
        // timer 0: split into two 8-bit counters or normal step
        if (split0) begin
            if (inc0) begin
                cnt0_next.low_byte = lo_w[7:0]; // RULE_11
                ovf0 = lo_w[8]; // RULE_11
            end
            if (inc_hi) begin
                cnt0_next.high_byte = hi_w[7:0]; // RULE_12
                ovf1_set = hi_w[8]; // RULE_12
            end
        end else begin
            cnt0_next = st0.cnt;
            ovf0 = st0.ovf; // RULE_04
        end
        // timer 1 loses its flag to the split high byte
        cnt1_next = st1.cnt;
        if (!split0) begin
            ovf1_set = st1.ovf; // RULE_04
        end
        // software writes beat a same-cycle count step
        if (wr_en) begin
            if (paddr_i == dtc_pkg::OFS_MODE) begin
                mode_next = wbyte;
            end else if (paddr_i == dtc_pkg::OFS_CTRL) begin
                ctrl_next = wbyte; // RULE_14 RULE_15
            end else if (paddr_i == dtc_pkg::OFS_LOW0) begin
                cnt0_next.low_byte = wbyte;
            end else if (paddr_i == dtc_pkg::OFS_HIGH0) begin
                cnt0_next.high_byte = wbyte;
            end else if (paddr_i == dtc_pkg::OFS_LOW1) begin
                cnt1_next.low_byte = wbyte;
            end else if (paddr_i == dtc_pkg::OFS_HIGH1) begin
                cnt1_next.high_byte = wbyte;
            end
        end
        // vector clears, then hardware sets so an event is never lost
        if (svc_timer0_i) begin
            ctrl_next[dtc_pkg::CTL_OVF0] = 1'b0; // RULE_15
        end
        if (svc_timer1_i) begin
            ctrl_next[dtc_pkg::CTL_OVF1] = 1'b0; // RULE_15
        end
        if (svc_ext0_i && ctrl_reg[dtc_pkg::CTL_XT0]) begin
            ctrl_next[dtc_pkg::CTL_XE0] = 1'b0; // RULE_16
        end
        if (svc_ext1_i && ctrl_reg[dtc_pkg::CTL_XT1]) begin
            ctrl_next[dtc_pkg::CTL_XE1] = 1'b0; // RULE_16
        end
        if (ovf0) begin
            ctrl_next[dtc_pkg::CTL_OVF0] = 1'b1; // RULE_04
        end
        if (ovf1_set) begin
            ctrl_next[dtc_pkg::CTL_OVF1] = 1'b1; // RULE_04
        end
        // edge mode latches a fall; level mode follows the low pin
        if (ctrl_reg[dtc_pkg::CTL_XT0]) begin
            if (pin_fall[dtc_pkg::PIN_GT0]) begin
                ctrl_next[dtc_pkg::CTL_XE0] = 1'b1; // RULE_16
            end
        end else begin
            ctrl_next[dtc_pkg::CTL_XE0] = ~pin_level[dtc_pkg::PIN_GT0];
        end
        if (ctrl_reg[dtc_pkg::CTL_XT1]) begin
            if (pin_fall[dtc_pkg::PIN_GT1]) begin
                ctrl_next[dtc_pkg::CTL_XE1] = 1'b1; // RULE_16
            end
        end else begin
            ctrl_next[dtc_pkg::CTL_XE1] = ~pin_level[dtc_pkg::PIN_GT1];
        end
        // baud tick stays on timer 1 even while timer 0 is split
        baud_next = st1.ovf; // RULE_13
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            mode_reg <= dtc_pkg::MODE_RST;
            ctrl_reg <= dtc_pkg::CTRL_RST;
            cnt0_reg <= {dtc_pkg::CNT_RST, dtc_pkg::CNT_RST};
            cnt1_reg <= {dtc_pkg::CNT_RST, dtc_pkg::CNT_RST};
            baud_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            ctrl_reg <= ctrl_next;
            cnt0_reg <= cnt0_next;
            cnt1_reg <= cnt1_next;
            baud_reg <= baud_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign prdata_o = rdata_reg;
    assign pready_o = ready_reg;
    assign pslverr_o = err_reg;
    assign timer0_irq_o = ctrl_reg[dtc_pkg::CTL_OVF0];
    assign timer1_irq_o = ctrl_reg[dtc_pkg::CTL_OVF1];
    assign ext_irq0_o = ctrl_reg[dtc_pkg::CTL_XE0];
    assign ext_irq1_o = ctrl_reg[dtc_pkg::CTL_XE1];
    assign baud_tick_o = baud_reg;

endmodule : dtc_timer_pair

`default_nettype wire

// file: verif/dtc_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// port checker for the timer pair
// ----------------------------------------------------------------
module dtc_assertions (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [dtc_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic timer0_irq_o,
    input wire logic timer1_irq_o,
    input wire logic baud_tick_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    // a control write landing at this edge
    logic ctl_wr;
    assign ctl_wr = psel_i && penable_i && pready_o && pwrite_i
        && pstrb_i[0] && !pslverr_o && paddr_i == dtc_pkg::OFS_CTRL;

    chk_zero_wait:
        assert property (psel_i && !penable_i |=> pready_o)
        else $error("ready missing after setup");
    chk_ready_one:
        assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    chk_bad_addr:
        assert property (psel_i && !penable_i
            && paddr_i > dtc_pkg::OFS_HIGH1 |=> pslverr_o && prdata_o == 0)
        else $error("unmapped access not refused");
    chk_byte_wide:
        assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("read data above bit 7");
    chk_idle_quiet:
        assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
        else $error("bus outputs not quiet");
    chk_tick_pulse:
        assert property (baud_tick_o |=> !baud_tick_o)
        else $error("baud tick longer than a cycle");
    chk_ovf0_sw:
        assert property (ctl_wr && pwdata_i[dtc_pkg::CTL_OVF0] |=> timer0_irq_o)
        else $error("software set of flag 0 lost");
    chk_ovf1_sw:
        assert property (ctl_wr && pwdata_i[dtc_pkg::CTL_OVF1] |=> timer1_irq_o)
        else $error("software set of flag 1 lost");
endmodule : dtc_assertions

bind dtc_timer_pair dtc_assertions u_chk (.clock_i, .reset_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .pready_o, .pslverr_o, .timer0_irq_o, .timer1_irq_o, .baud_tick_o);

`default_nettype wire

// file: verif/dtc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// event and gate pins seen from outside
// ----------------------------------------------------------------
module dtc_pin_model (
    input wire logic clock_i,
    output logic [dtc_pkg::PIN_N-1:0] pins_o
);
    // idle high like pulled-up port lines
    initial pins_o = {dtc_pkg::PIN_N{1'b1}};

    // low and high phases long enough for the two-stage sampler
    task fall(input int i);
        @(posedge clock_i);
        pins_o[i] <= 1'b0;
        repeat (2) @(posedge clock_i);
        pins_o[i] <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask : fall

    task level(input int i, input logic v);
        @(posedge clock_i);
        pins_o[i] <= v;
    endtask : level
endmodule : dtc_pin_model

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] strb = 4'hF;
    logic [3:0] svc = 4'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, tick;
    wire logic [3:0] irqs;
    wire logic [3:0] pins;
    int err_count = 0;
    int n_compared = 0;
    int baud_seen = 0;
    int n;
    int b;
    logic [31:0] rd;
    logic er;

    dtc_timer_pair dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(strb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .event0_i(pins[dtc_pkg::PIN_EV0]), .event1_i(pins[dtc_pkg::PIN_EV1]),
        .ext_gate_pin0_i(pins[dtc_pkg::PIN_GT0]),
        .ext_gate_pin1_i(pins[dtc_pkg::PIN_GT1]),
        .svc_timer0_i(svc[0]), .svc_timer1_i(svc[1]),
        .svc_ext0_i(svc[2]), .svc_ext1_i(svc[3]),
        .timer0_irq_o(irqs[0]), .timer1_irq_o(irqs[1]),
        .ext_irq0_o(irqs[2]), .ext_irq1_o(irqs[3]), .baud_tick_o(tick));
    dtc_pin_model pm (.clock_i(clock_i), .pins_o(pins));

    // ----------------------------------------------------------------
    // clock, tick counter, watchdog
    // ----------------------------------------------------------------
    initial forever #2 clock_i = ~clock_i;
    always @(posedge clock_i) if (tick === 1'b1) baud_seen <= baud_seen + 1;
    // far above the roughly 350 cycles the run needs
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdc(input string what, input logic [11:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        chk(what, rd, {24'h0, e});
    endtask : rdc

    task pulse(input int i);
        @(posedge clock_i);
        svc[i] <= 1'b1;
        @(posedge clock_i);
        svc[i] <= 1'b0;
        @(posedge clock_i);
    endtask : pulse

    task wait_irq(input int i, input int lim);
        n = 0;
        while (irqs[i] !== 1'b1 && n < lim) begin
            @(posedge clock_i);
            n++;
        end
    endtask : wait_irq

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        for (int i = 0; i < 6; i++) begin
            rdc("reset value", 12'(i * 4), i == 0 ? dtc_pkg::MODE_RST
                : i == 1 ? dtc_pkg::CTRL_RST : dtc_pkg::CNT_RST);
        end
        apb(12'h018, 1'b0, 8'h00);
        chk("unmapped error", {31'h0, er}, 32'h1);
        strb <= 4'h0;
        apb(dtc_pkg::OFS_MODE, 1'b1, 8'hFF);
        strb <= 4'hF;
        rdc("masked write", dtc_pkg::OFS_MODE, 8'h00);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'hA0);
        rdc("ctrl flags", dtc_pkg::OFS_CTRL, 8'hA0);
        chk("flag outputs", {28'h0, irqs}, 32'h3);
        pulse(0);
        pulse(1);
        chk("service clear", {28'h0, irqs}, 32'h0);
    endtask : t_regs

    // mode 1 from FFFE and mode 0 from all ones both wrap
    task t_count;
        for (int i = 0; i < 2; i++) begin
            apb(dtc_pkg::OFS_HIGH0, 1'b1, 8'hFF);
            apb(dtc_pkg::OFS_LOW0, 1'b1, i ? 8'hFF : 8'hFE);
            apb(dtc_pkg::OFS_MODE, 1'b1, i ? 8'h00 : 8'h01);
            apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h10);
            wait_irq(0, 40);
            chk("overflow flag", {31'h0, irqs[0]}, 32'h1);
            apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h20);
            rdc("low after wrap", dtc_pkg::OFS_LOW0, i ? 8'hE0 : 8'h00);
            rdc("high after wrap", dtc_pkg::OFS_HIGH0, 8'h00);
            pulse(0);
            chk("flag serviced", {31'h0, irqs[0]}, 32'h0);
        end
    endtask : t_count

    task t_gate;
        apb(dtc_pkg::OFS_LOW0, 1'b1, 8'h00);
        apb(dtc_pkg::OFS_MODE, 1'b1, 8'h09);
        pm.level(dtc_pkg::PIN_GT0, 1'b0);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h10);
        repeat (40) @(posedge clock_i);
        rdc("gated hold", dtc_pkg::OFS_LOW0, 8'h00);
        pm.level(dtc_pkg::PIN_GT0, 1'b1);
        repeat (40) @(posedge clock_i);
        apb(dtc_pkg::OFS_LOW0, 1'b0, 8'h00);
        chk("gate open counts", {31'h0, rd != 0}, 32'h1);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h00);
    endtask : t_gate

    // timer 1 counts pin events in reload mode
    task t_event;
        apb(dtc_pkg::OFS_MODE, 1'b1, 8'h60);
        apb(dtc_pkg::OFS_HIGH1, 1'b1, 8'hF0);
        apb(dtc_pkg::OFS_LOW1, 1'b1, 8'hFE);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h40);
        repeat (30) @(posedge clock_i);
        rdc("no cycle count", dtc_pkg::OFS_LOW1, 8'hFE);
        b = baud_seen;
        repeat (3) pm.fall(dtc_pkg::PIN_EV1);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h80);
        rdc("reloaded low", dtc_pkg::OFS_LOW1, 8'hF1);
        rdc("high kept", dtc_pkg::OFS_HIGH1, 8'hF0);
        chk("event overflow", {31'h0, irqs[1]}, 32'h1);
        chk("baud ticks", baud_seen - b, 32'h1);
        pulse(1);
    endtask : t_event

    // split timer 0, timer 1 parked in mode 3
    task t_split;
        apb(dtc_pkg::OFS_MODE, 1'b1, 8'h33);
        apb(dtc_pkg::OFS_HIGH0, 1'b1, 8'hFF);
        apb(dtc_pkg::OFS_LOW0, 1'b1, 8'h00);
        apb(dtc_pkg::OFS_LOW1, 1'b1, 8'hAA);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h40);
        wait_irq(1, 40);
        chk("split high flag", {31'h0, irqs[1]}, 32'h1);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h00);
        rdc("split low idle", dtc_pkg::OFS_LOW0, 8'h00);
        rdc("timer 1 held", dtc_pkg::OFS_LOW1, 8'hAA);
        chk("flag 0 quiet", {31'h0, irqs[0]}, 32'h0);
        pulse(1);
    endtask : t_split

    task t_ext;
        apb(dtc_pkg::OFS_MODE, 1'b1, 8'h00);
        apb(dtc_pkg::OFS_CTRL, 1'b1, 8'h01);
        pm.fall(dtc_pkg::PIN_GT0);
        wait_irq(2, 10);
        chk("edge flag", {31'h0, irqs[2]}, 32'h1);
        pulse(2);
        @(posedge clock_i);
        chk("edge serviced", {31'h0, irqs[2]}, 32'h0);
    endtask : t_ext

    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (4) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_count();
        t_gate();
        t_event();
        t_split();
        t_ext();
        wrap_up();
    end
endmodule : tb

`default_nettype wire
